// File: design/cps_pkg.sv
// Shared constants, register map and field layout of the PHY config block.
// Assumes a 32-bit classic Wishbone slave with 12 address bits.
package cps_pkg;
  localparam int DATA_W    = 32;
  localparam int ADR_W     = 12;
  localparam int LANES     = 4;
  localparam int LANE_REGS = 5;
  localparam int IDX_W     = 3;

  // Common registers (byte addresses)
  localparam logic [11:0] OFS_COMP_CTRL = 12'h000;
  localparam logic [11:0] OFS_COMP_REF1 = 12'h004;
  localparam logic [11:0] OFS_COMP_STAT = 12'h008;
  localparam logic [11:0] OFS_COMP_IREF = 12'h00c;
  localparam logic [11:0] OFS_COMP_REF9 = 12'h010;
  localparam logic [11:0] OFS_COMP_REFA = 12'h014;
  localparam logic [11:0] OFS_PHY_MISCELLANEOUS_CONTROL  = 12'h018;
  localparam logic [11:0] OFS_CL_CTRL   = 12'h01c;
  localparam logic [11:0] OFS_PCS_CTRL  = 12'h020;
  // Lane window: lane n at LANE_BASE + n*OFS_LANE_STEP, group copy at GROUP
  localparam logic [3:0]  REGION_LANE   = 4'h1;
  localparam logic [3:0]  REGION_GROUP  = 4'h2;
  localparam logic [11:0] OFS_LANE_BASE = 12'h100;
  localparam logic [11:0] OFS_LANE_STEP = 12'h040;
  localparam logic [11:0] OFS_GROUP     = 12'h200;
  // Lane register indices
  localparam logic [2:0] IDX_SWING = 3'h0;
  localparam logic [2:0] IDX_COEF  = 3'h1;
  localparam logic [2:0] IDX_TRAIN = 3'h2;
  localparam logic [2:0] IDX_NSCAL = 3'h3;
  localparam logic [2:0] IDX_DCC   = 3'h4;

  // Field positions
  localparam int COMP_INIT_BIT   = 0;
  localparam int IREFGEN_BIT     = 0;
  localparam int COMP_PD_BIT     = 0;
  localparam int CL_PD_BIT       = 0;
  localparam int SUS_CLK_LSB     = 2;
  localparam int SERIAL_MODE_BIT = 4;
  localparam int KEEPER_BIT      = 0;
  localparam int DUTY_MODE_LSB   = 1;
  localparam int STAT_PROC_BIT   = 2;
  localparam int SWING_LSB       = 0;
  localparam int POST1_LSB       = 0;
  localparam int CURSOR_LSB      = 12;
  localparam int TWO_TAP_BIT     = 29;
  localparam int TRAIN_EN_BIT    = 31;
  localparam int NSCAL_LSB       = 24;

  // Values after reset
  localparam logic [31:0] RST_PHY_MISCELLANEOUS_CONTROL = 32'h0000_0001;
  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_ACK  = 3'b100
  } cps_bus_st_t;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] cps_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[b*8 +: 8] = new_w[b*8 +: 8];
    end
    return res;
  endfunction : cps_merge
endpackage : cps_pkg

// File: design/cps_lane_if.sv
// Carrier between the bus slave, the lane register store and the applier.
// Assumes all three share one clock.
`timescale 1ns/1ps
interface cps_lane_if;
  logic        wr;
  logic [3:0]  lane_mask;
  logic [2:0]  idx;
  logic [31:0] wdata;
  logic [3:0]  sel;
  logic [1:0]  rd_lane;
  logic [2:0]  rd_idx;
  logic [31:0] rd_data;

  modport ctrl  (output wr, lane_mask, idx, wdata, sel, rd_lane, rd_idx,
                 input  rd_data);
  modport store (input  wr, lane_mask, idx, wdata, sel, rd_lane, rd_idx,
                 output rd_data);
  modport snoop (input  wr, lane_mask, idx, wdata, sel);
endinterface : cps_lane_if

// File: design/cps_lane_mem.sv
// Per-lane register store; a write may hit several lanes at once.
// Assumes read address is held for one cycle; read data is registered.
`timescale 1ns/1ps
module cps_lane_mem
  import cps_pkg::*;
#(
  parameter int NLANES = 4,
  parameter int DEPTH  = 8
)(
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  cps_lane_if.store   bus
);
  logic [31:0] mem_reg [NLANES*DEPTH];

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < NLANES*DEPTH; i++)
        mem_reg[i] <= RST_ZERO;
      bus.rd_data <= RST_ZERO;
    end
    else
    begin
      for (int l = 0; l < NLANES; l++)
      begin
        if (bus.wr && bus.lane_mask[l])
          mem_reg[l*DEPTH + int'(bus.idx)] <=
            cps_merge(mem_reg[l*DEPTH + int'(bus.idx)], bus.wdata, bus.sel);
      end
      bus.rd_data <= mem_reg[int'(bus.rd_lane)*DEPTH + int'(bus.rd_idx)];
    end
  end
endmodule : cps_lane_mem

// File: design/cps_tx_apply.sv
// Shadows lane swing fields and applies them when training enable rises.
// Assumes the write carrier from the bus slave; outputs are flops.
`timescale 1ns/1ps
module cps_tx_apply
  import cps_pkg::*;
#(
  parameter int NLANES = 4
)(
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  cps_lane_if.snoop               bus,
  output logic [NLANES*4-1:0]     hs_swing_o,
  output logic [NLANES*6-1:0]     cursor_o,
  output logic [NLANES*6-1:0]     post1_o,
  output logic [NLANES*7-1:0]     nscalar_o,
  output logic [NLANES-1:0]       two_tap_dis_o,
  output logic [NLANES-1:0]       apply_o
);
  logic [31:0] sh_swing_reg [NLANES];
  logic [31:0] sh_coef_reg  [NLANES];
  logic [31:0] sh_train_reg [NLANES];
  logic [31:0] sh_nscal_reg [NLANES];
  logic [31:0] train_next   [NLANES];
  logic [NLANES-1:0] rise;

  always_comb
  begin
    for (int l = 0; l < NLANES; l++)
    begin
      train_next[l] = cps_merge(sh_train_reg[l], bus.wdata, bus.sel);
      rise[l] = bus.wr && bus.lane_mask[l] && (bus.idx == IDX_TRAIN) &&
                !sh_train_reg[l][TRAIN_EN_BIT] &&
                train_next[l][TRAIN_EN_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int l = 0; l < NLANES; l++)
      begin
        sh_swing_reg[l] <= RST_ZERO;
        sh_coef_reg[l]  <= RST_ZERO;
        sh_train_reg[l] <= RST_ZERO;
        sh_nscal_reg[l] <= RST_ZERO;
      end
      hs_swing_o    <= '0;
      cursor_o      <= '0;
      post1_o       <= '0;
      nscalar_o     <= '0;
      two_tap_dis_o <= '0;
      apply_o       <= '0;
    end
    else
    begin
      apply_o <= rise;
      for (int l = 0; l < NLANES; l++)
      begin
        if (bus.wr && bus.lane_mask[l])
        begin
          case (bus.idx)
            IDX_SWING: sh_swing_reg[l] <=
                         cps_merge(sh_swing_reg[l], bus.wdata, bus.sel);
            IDX_COEF:  sh_coef_reg[l]  <=
                         cps_merge(sh_coef_reg[l], bus.wdata, bus.sel);
            IDX_TRAIN: sh_train_reg[l] <= train_next[l];
            IDX_NSCAL: sh_nscal_reg[l] <=
                         cps_merge(sh_nscal_reg[l], bus.wdata, bus.sel);
            default:   sh_train_reg[l] <= sh_train_reg[l];
          endcase
        end
        // New coefficients reach the transmitter only on the enable edge
        if (rise[l]) // [RULE17]
        begin
          hs_swing_o[l*4 +: 4] <= sh_swing_reg[l][SWING_LSB +: 4];
          cursor_o[l*6 +: 6]   <= sh_coef_reg[l][CURSOR_LSB +: 6];
          post1_o[l*6 +: 6]    <= sh_coef_reg[l][POST1_LSB +: 6];
          nscalar_o[l*7 +: 7]  <= sh_nscal_reg[l][NSCAL_LSB +: 7];
          two_tap_dis_o[l]     <= train_next[l][TWO_TAP_BIT];
        end
      end
    end
  end
endmodule : cps_tx_apply

// File: design/cps_top.sv
// Combo PHY configuration register block behind a classic Wishbone slave.
// Assumes a single clock and a master that holds its request until ACK_O.
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// [RULE1] A group-address write stores the value into all 4 lane copies.
// [RULE2] Software reads one lane, then writes merged value to group address.
// [RULE3] Compensation source is initialised before sinks or PLLs; stays up.
// [RULE4] Initialise the PHY before enabling its display or aux power.
// [RULE5] Initialisation starts by reading the init flag; set means skip.
// [RULE6] Duty-correction clock select 1, divider 00, then continuous mode.
// [RULE7] Clear compensation power-down bit, if this port has that register.
// [RULE8] Load three process-monitor references chosen by voltage and process.
// [RULE9] Only a compensation source sets the reference-current enable.
// [RULE10] Finish by setting init flag, then common-lane power-down enable.
// [RULE11] Deepest state only: set power-down, then clear init flag.
// [RULE12] First PHY keeps init state across the intermediate low-power state.
// [RULE13] Keeper enable 1 for DisplayPort types, else 0, at swing start.
// [RULE14] Load-generator select per lane depends on bit rate and lane count.
// [RULE15] Per-lane coefficient register is written per lane, never grouped.
// [RULE16] Suspend clock configuration field is set to 11 during swing setup.
// [RULE17] Training enable cleared before swing change; rise applies values.
// [RULE18] Scaling mode 010, compensation scalar 0x98, second post-cursor 0.
// [RULE19] Termination 110, three-tap disable 1, cursor program 0, polarity 0.
// [RULE20] Swing, N scalar, cursor, post-cursor, two-tap from lookup table.
// [RULE21] Serial display mode: low-power buffer swing handled in hardware.
// [RULE22] A sequencer issues writes in order, one at a time, then done.
module cps_top
  import cps_pkg::*;
#(
  parameter bit         FIRST_PHY   = 1'b1,
  parameter logic [3:0] LP_SWING    = 4'h5
)(
  input  wire logic                CLK_I,
  input  wire logic                RST_N_I,
  input  wire logic                CYC_I,
  input  wire logic                STB_I,
  input  wire logic                WE_I,
  input  wire logic [ADR_W-1:0]    ADR_I,
  input  wire logic [3:0]          SEL_I,
  input  wire logic [DATA_W-1:0]   DAT_I,
  input  wire logic [1:0]          SUPPLY_SEL_I,
  input  wire logic                PROCESS_STEP_I,
  input  wire logic                LOWPOWER_I,
  output logic [DATA_W-1:0]        DAT_O,
  output logic                     ACK_O,
  output logic                     COMP_INIT_O,
  output logic                     COMP_PWRDN_O,
  output logic                     IREFGEN_EN_O,
  output logic                     CL_PWRDN_EN_O,
  output logic [1:0]               SUS_CLK_CFG_O,
  output logic                     KEEPER_EN_O,
  output logic [1:0]               DUTY_MODE_O,
  output logic [LANES*4-1:0]       HS_SWING_O,
  output logic [LANES*6-1:0]       CURSOR_O,
  output logic [LANES*6-1:0]       POST1_O,
  output logic [LANES*7-1:0]       NSCALAR_O,
  output logic [LANES-1:0]         TWO_TAP_DIS_O,
  output logic [LANES-1:0]         COEF_APPLY_O,
  output logic [3:0]               LP_SWING_O
);
  cps_lane_if lane_bus ();

  cps_bus_st_t state_reg;
  cps_bus_st_t state_next;

  logic [31:0] comp_ctrl_reg;
  logic [31:0] comp_ref1_reg;
  logic [31:0] comp_iref_reg;
  logic [31:0] comp_ref9_reg;
  logic [31:0] comp_refa_reg;
  logic [31:0] phy_miscellaneous_control_reg;
  logic [31:0] cl_ctrl_reg;
  logic [31:0] pcs_ctrl_reg;
  logic        lowpower_reg;
  logic        is_lane_reg;

  // Address decode
  wire         req       = CYC_I && STB_I && (state_reg == ST_IDLE);
  wire [3:0]   region    = ADR_I[11:8];
  wire [2:0]   lane_idx  = ADR_I[4:2];
  wire         idx_ok    = (ADR_I[5] == 1'b0) &&
                           (lane_idx < IDX_W'(LANE_REGS)) &&
                           (ADR_I[1:0] == 2'b00);
  wire         hit_lane  = (region == REGION_LANE) && idx_ok;
  wire         hit_group = (region == REGION_GROUP) &&
                           (ADR_I[7:6] == 2'b00) && idx_ok;
  wire         hit_comp_ctrl = (ADR_I == OFS_COMP_CTRL);
  wire         hit_ref1  = (ADR_I == OFS_COMP_REF1);
  wire         hit_iref  = (ADR_I == OFS_COMP_IREF);
  wire         hit_ref9  = (ADR_I == OFS_COMP_REF9);
  wire         hit_refa  = (ADR_I == OFS_COMP_REFA);
  wire         hit_misc  = (ADR_I == OFS_PHY_MISCELLANEOUS_CONTROL);
  wire         hit_cl    = (ADR_I == OFS_CL_CTRL);
  wire         hit_pcs   = (ADR_I == OFS_PCS_CTRL);
  wire         wr        = req && WE_I;
  wire [3:0]   one_lane  = 4'h1 << ADR_I[7:6];

  // Status word: supply and process step seen by the PHY
  wire [31:0]  comp_stat = {29'h0, PROCESS_STEP_I, SUPPLY_SEL_I};

  // Leaving the intermediate low-power state drops non-first PHY state
  wire         lp_exit   = lowpower_reg && !LOWPOWER_I;
  wire         lose_init = lp_exit && !FIRST_PHY; // [RULE12]

  // Lane store and applier share the write carrier
  assign lane_bus.wr        = wr && (hit_lane || hit_group);
  assign lane_bus.lane_mask = hit_group ? 4'hf : one_lane; // [RULE1]
  assign lane_bus.idx       = lane_idx;
  assign lane_bus.wdata     = DAT_I;
  assign lane_bus.sel       = SEL_I;
  assign lane_bus.rd_lane   = ADR_I[7:6];
  assign lane_bus.rd_idx    = lane_idx;

  wire [31:0] common_rd =
      hit_comp_ctrl ? comp_ctrl_reg :
      hit_ref1      ? comp_ref1_reg :
      (ADR_I == OFS_COMP_STAT) ? comp_stat :
      hit_iref      ? comp_iref_reg :
      hit_ref9      ? comp_ref9_reg :
      hit_refa      ? comp_refa_reg :
      hit_misc      ? phy_miscellaneous_control_reg  :
      hit_cl        ? cl_ctrl_reg   :
      hit_pcs       ? pcs_ctrl_reg  : RST_ZERO;

  cps_lane_mem #(
    .NLANES (LANES),
    .DEPTH  (8)
  ) u_mem (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .bus     (lane_bus)
  );

  cps_tx_apply #(
    .NLANES (LANES)
  ) u_apply (
    .clk_i         (CLK_I),
    .rst_n_i       (RST_N_I),
    .bus           (lane_bus),
    .hs_swing_o    (HS_SWING_O),
    .cursor_o      (CURSOR_O),
    .post1_o       (POST1_O),
    .nscalar_o     (NSCALAR_O),
    .two_tap_dis_o (TWO_TAP_DIS_O),
    .apply_o       (COEF_APPLY_O)
  );

  // Bus handshake: take, settle read data, answer, release
  always_comb
  begin
    case (state_reg)
      ST_IDLE: state_next = req ? ST_WAIT : ST_IDLE;
      ST_WAIT: state_next = ST_ACK;
      ST_ACK:  state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_reg   <= ST_IDLE;
      is_lane_reg <= 1'b0;
      ACK_O       <= 1'b0;
      DAT_O       <= RST_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      ACK_O     <= (state_reg == ST_WAIT);
      if (req)
        is_lane_reg <= hit_lane;
      // Group reads have no meaning and return zero
      if (state_reg == ST_WAIT)
        DAT_O <= is_lane_reg ? lane_bus.rd_data : common_rd;
    end
  end

  // Common registers; the state loss is applied before a same-cycle write
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      comp_ctrl_reg <= RST_ZERO;
      comp_ref1_reg <= RST_ZERO;
      comp_iref_reg <= RST_ZERO;
      comp_ref9_reg <= RST_ZERO;
      comp_refa_reg <= RST_ZERO;
      phy_miscellaneous_control_reg  <= RST_PHY_MISCELLANEOUS_CONTROL;
      cl_ctrl_reg   <= RST_ZERO;
      pcs_ctrl_reg  <= RST_ZERO;
      lowpower_reg  <= 1'b0;
    end
    else
    begin
      lowpower_reg <= LOWPOWER_I;
      if (lose_init) // [RULE12]
      begin
        comp_ctrl_reg[COMP_INIT_BIT] <= 1'b0;
        cl_ctrl_reg[CL_PD_BIT]       <= 1'b0;
        phy_miscellaneous_control_reg[COMP_PD_BIT]    <= 1'b1;
      end
      if (wr && hit_comp_ctrl)
        comp_ctrl_reg <= cps_merge(comp_ctrl_reg, DAT_I, SEL_I);
      if (wr && hit_ref1)
        comp_ref1_reg <= cps_merge(comp_ref1_reg, DAT_I, SEL_I);
      if (wr && hit_iref)
        comp_iref_reg <= cps_merge(comp_iref_reg, DAT_I, SEL_I);
      if (wr && hit_ref9)
        comp_ref9_reg <= cps_merge(comp_ref9_reg, DAT_I, SEL_I);
      if (wr && hit_refa)
        comp_refa_reg <= cps_merge(comp_refa_reg, DAT_I, SEL_I);
      if (wr && hit_misc)
        phy_miscellaneous_control_reg  <= cps_merge(phy_miscellaneous_control_reg, DAT_I, SEL_I);
      if (wr && hit_cl)
        cl_ctrl_reg   <= cps_merge(cl_ctrl_reg, DAT_I, SEL_I);
      if (wr && hit_pcs)
        pcs_ctrl_reg  <= cps_merge(pcs_ctrl_reg, DAT_I, SEL_I);
    end
  end

  // Control outputs follow the stored fields one cycle later
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      COMP_INIT_O   <= 1'b0;
      COMP_PWRDN_O  <= RST_PHY_MISCELLANEOUS_CONTROL[COMP_PD_BIT];
      IREFGEN_EN_O  <= 1'b0;
      CL_PWRDN_EN_O <= 1'b0;
      SUS_CLK_CFG_O <= 2'h0;
      KEEPER_EN_O   <= 1'b0;
      DUTY_MODE_O   <= 2'h0;
      LP_SWING_O    <= 4'h0;
    end
    else
    begin
      COMP_INIT_O   <= comp_ctrl_reg[COMP_INIT_BIT];
      COMP_PWRDN_O  <= phy_miscellaneous_control_reg[COMP_PD_BIT];
      IREFGEN_EN_O  <= comp_iref_reg[IREFGEN_BIT];
      CL_PWRDN_EN_O <= cl_ctrl_reg[CL_PD_BIT];
      SUS_CLK_CFG_O <= cl_ctrl_reg[SUS_CLK_LSB +: 2];
      KEEPER_EN_O   <= pcs_ctrl_reg[KEEPER_BIT];
      DUTY_MODE_O   <= pcs_ctrl_reg[DUTY_MODE_LSB +: 2];
      // In serial mode low-power buffers get a fixed swing; programmed swing is high-speed
      LP_SWING_O    <= cl_ctrl_reg[SERIAL_MODE_BIT] ? LP_SWING : 4'h0; // [RULE21]
    end
  end
endmodule : cps_top

// File: verif/cps_top_sva.sv
// Port-level checks of the PHY config block: bus answer, apply, kept state.
// Assumes it is bound into cps_top and sees that instance's ports only.
`timescale 1ns/1ps
module cps_top_sva
  import cps_pkg::*;
#(
  parameter bit         FIRST_PHY = 1'b1,
  parameter logic [3:0] LP_SWING  = 4'h5
)(
  input wire logic              CLK_I,
  input wire logic              RST_N_I,
  input wire logic              CYC_I,
  input wire logic              STB_I,
  input wire logic              WE_I,
  input wire logic [ADR_W-1:0]  ADR_I,
  input wire logic [3:0]        SEL_I,
  input wire logic [DATA_W-1:0] DAT_I,
  input wire logic [1:0]        SUPPLY_SEL_I,
  input wire logic              PROCESS_STEP_I,
  input wire logic              LOWPOWER_I,
  input wire logic [DATA_W-1:0] DAT_O,
  input wire logic              ACK_O,
  input wire logic              COMP_INIT_O,
  input wire logic [LANES*4-1:0] HS_SWING_O,
  input wire logic [LANES*6-1:0] CURSOR_O,
  input wire logic [LANES*7-1:0] NSCALAR_O,
  input wire logic [LANES-1:0]  COEF_APPLY_O,
  input wire logic [3:0]        LP_SWING_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire req    = CYC_I && STB_I;
  wire rd_ack = ACK_O && !WE_I;
  wire wr_lo  = WE_I && SEL_I[0];

  chk_ack_delay: assert property ($rose(req) |-> !ACK_O [*2] ##1 ACK_O)
    else $error("bus answer not two cycles after request");
  chk_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("bus answer longer than one cycle");
  chk_refused_read: assert property (rd_ack && ADR_I >= OFS_GROUP
    |-> DAT_O == '0) else $error("group or unmapped read not zero");
  chk_status_read: assert property (rd_ack && ADR_I == OFS_COMP_STAT
    |-> DAT_O[2:0] == {PROCESS_STEP_I, SUPPLY_SEL_I})
    else $error("status read wrong");
  chk_init_follow: assert property ($rose(req) && wr_lo &&
    ADR_I == OFS_COMP_CTRL |-> ##2 COMP_INIT_O == DAT_I[0])
    else $error("init flag output wrong");
  chk_lp_swing: assert property ($rose(req) && wr_lo &&
    ADR_I == OFS_CL_CTRL |-> ##2
    LP_SWING_O == (DAT_I[SERIAL_MODE_BIT] ? LP_SWING : 4'h0))
    else $error("low-power swing wrong");
  chk_apply_cause: assert property (|COEF_APPLY_O |->
    $past(req && WE_I)) else $error("apply without write");
  chk_apply_only: assert property (!$stable({HS_SWING_O, CURSOR_O,
    NSCALAR_O}) |-> |COEF_APPLY_O) else $error("coefficients moved alone");
  chk_keep_state: assert property (FIRST_PHY && $fell(LOWPOWER_I) &&
    !CYC_I |=> $stable(COMP_INIT_O) [*2]) else $error("init state lost");

  cover property ($rose(req) && WE_I && ADR_I[11:8] == REGION_GROUP);
  cover property (|COEF_APPLY_O);
  cover property ($fell(LOWPOWER_I) && COMP_INIT_O);
endmodule : cps_top_sva

bind cps_top cps_top_sva #(.FIRST_PHY(FIRST_PHY), .LP_SWING(LP_SWING))
  u_cps_top_sva (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
  .SUPPLY_SEL_I(SUPPLY_SEL_I), .PROCESS_STEP_I(PROCESS_STEP_I),
  .LOWPOWER_I(LOWPOWER_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .COMP_INIT_O(COMP_INIT_O), .HS_SWING_O(HS_SWING_O), .CURSOR_O(CURSOR_O),
  .NSCALAR_O(NSCALAR_O), .COEF_APPLY_O(COEF_APPLY_O),
  .LP_SWING_O(LP_SWING_O));

// File: verif/cps_top_test.sv
// Self-checking bench of the PHY config block over classic Wishbone.
// Assumes cps_top with default parameters plus a FIRST_PHY=0 copy, and a 100 ns clock.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module cps_top_test
  import cps_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] dat = '0;
  logic [1:0]  supply = 2'b01;
  logic        proc = 1'b1, lowpower = 1'b0;
  logic [31:0] rdat;
  logic        ack, init, pdn, iref, clpd, keep, init2, clpd2, pdn2;
  logic [1:0]  sus, duty;
  logic [15:0] swing;
  logic [23:0] cursor, post1;
  logic [27:0] nscal;
  logic [3:0]  ttap, lpsw;
  int          num_errors = 0;
  int          check_count = 0;

  cps_top u_cps_top (.CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat),
    .SUPPLY_SEL_I(supply), .PROCESS_STEP_I(proc), .LOWPOWER_I(lowpower),
    .DAT_O(rdat), .ACK_O(ack), .COMP_INIT_O(init), .COMP_PWRDN_O(pdn),
    .IREFGEN_EN_O(iref), .CL_PWRDN_EN_O(clpd), .SUS_CLK_CFG_O(sus),
    .KEEPER_EN_O(keep), .DUTY_MODE_O(duty), .HS_SWING_O(swing),
    .CURSOR_O(cursor), .POST1_O(post1), .NSCALAR_O(nscal),
    .TWO_TAP_DIS_O(ttap), .COEF_APPLY_O(), .LP_SWING_O(lpsw));

  // Non-first PHY copy: drops its init state on leaving low power
  cps_top #(.FIRST_PHY(1'b0)) u_cps_top_sink (.CLK_I(clk), .RST_N_I(rst_n),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
    .DAT_I(dat), .SUPPLY_SEL_I(supply), .PROCESS_STEP_I(proc),
    .LOWPOWER_I(lowpower), .DAT_O(), .ACK_O(), .COMP_INIT_O(init2),
    .COMP_PWRDN_O(pdn2), .IREFGEN_EN_O(), .CL_PWRDN_EN_O(clpd2),
    .SUS_CLK_CFG_O(), .KEEPER_EN_O(), .DUTY_MODE_O(), .HS_SWING_O(),
    .CURSOR_O(), .POST1_O(), .NSCALAR_O(), .TWO_TAP_DIS_O(),
    .COEF_APPLY_O(), .LP_SWING_O());

  initial
  begin
    forever #50 clk = ~clk;
  end

  function automatic logic [11:0] la(input int l, input logic [2:0] i);
    return OFS_LANE_BASE + OFS_LANE_STEP * 12'(l) + 12'(i) * 12'h004;
  endfunction : la

  function automatic logic [11:0] grp(input logic [2:0] i);
    return OFS_GROUP + 12'(i) * 12'h004;
  endfunction : grp

  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    `CHK(ack, 1'b1)
    {cyc, stb} <= 2'b00;
  endtask : wb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    wb(1'b0, a, '0, q);
  endtask : rd

  task automatic init_seq();
    logic [31:0] q;
    rd(OFS_PHY_MISCELLANEOUS_CONTROL, q);
    `CHK(q, RST_PHY_MISCELLANEOUS_CONTROL)
    rd(OFS_COMP_CTRL, q);
    `CHK(q[0], 1'b0)
    wr(grp(IDX_DCC), 32'h0000_0001);
    wr(OFS_PCS_CTRL, 32'h0000_0002);
    `CHK(duty, 2'b01)
    wr(OFS_PHY_MISCELLANEOUS_CONTROL, RST_ZERO);
    `CHK(pdn, 1'b0)
    rd(OFS_COMP_STAT, q);
    `CHK(q[2:0], 3'b101)
    wr(OFS_COMP_REF1, 32'h0000_0000);
    wr(OFS_COMP_REF9, 32'h93f8_7fe1);
    wr(OFS_COMP_REFA, 32'h8ae8_71c5);
    rd(OFS_COMP_REF9, q);
    `CHK(q, 32'h93f8_7fe1)
    wr(OFS_COMP_IREF, 32'h0000_0001);
    `CHK(iref, 1'b1)
    wr(OFS_COMP_CTRL, 32'h0000_0001);
    wr(OFS_CL_CTRL, 32'h0000_0001);
    `CHK({init, clpd}, 2'b11)
  endtask : init_seq

  task automatic low_power_keep();
    `CHK({init2, clpd2, pdn2}, 3'b110)
    @(posedge clk);
    lowpower <= 1'b1;
    repeat (3) @(posedge clk);
    lowpower <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK({init, clpd, pdn}, 3'b110)
    `CHK({init2, clpd2, pdn2}, 3'b001)
  endtask : low_power_keep

  task automatic swing_seq();
    logic [3:0]  sw [2] = '{4'ha, 4'h2};
    logic [6:0]  ns [2] = '{7'h32, 7'h7f};
    logic [5:0]  cu [2] = '{6'h3f, 6'h3f};
    logic [5:0]  po [2] = '{6'h00, 6'h00};
    logic        tt [2] = '{1'b0, 1'b1};
    logic [3:0]  lg;
    logic [31:0] fix, q;
    lg = 4'b1110;
    fix = 32'h0008_0070;
    wr(OFS_PCS_CTRL, 32'h0000_0003);
    `CHK(keep, 1'b1)
    wr(OFS_CL_CTRL, 32'h0000_000d);
    `CHK(sus, 2'b11)
    `CHK(lpsw, 4'h0)
    for (int s = 0; s < 2; s++)
    begin
      wr(grp(IDX_TRAIN), fix);
      wr(grp(IDX_SWING), 32'h0000_9800 | 32'(sw[s]));
      wr(grp(IDX_NSCAL), {1'b0, ns[s], 24'h0});
      for (int l = 0; l < 4; l++)
        wr(la(l, IDX_COEF), {lg[l], 13'h0, cu[s], 6'h0, po[s]});
      `CHK(swing, s ? {4{sw[0]}} : 16'h0)
      wr(grp(IDX_TRAIN), fix | {1'b1, 1'b0, tt[s], 29'h0});
      `CHK(swing, {4{sw[s]}})
      `CHK({cursor, post1}, {{4{cu[s]}}, {4{po[s]}}})
      `CHK({nscal, ttap}, {{4{ns[s]}}, {4{tt[s]}}})
      rd(la(2, IDX_TRAIN), q);
      `CHK(q, fix | {1'b1, 1'b0, tt[s], 29'h0})
      rd(la(3, IDX_COEF), q);
      `CHK(q[31], lg[3])
      rd(grp(IDX_TRAIN), q);
      `CHK(q, RST_ZERO)
    end
    wr(OFS_CL_CTRL, 32'h0000_001d);
    `CHK({lpsw, swing}, {4'h5, {4{sw[1]}}})
  endtask : swing_seq

  task automatic uninit_seq();
    logic [31:0] q;
    wr(OFS_PHY_MISCELLANEOUS_CONTROL, 32'h0000_0001);
    wr(OFS_COMP_CTRL, RST_ZERO);
    `CHK({pdn, init}, 2'b10)
    wr(12'h300, 32'hffff_ffff);
    rd(12'h300, q);
    `CHK(q, RST_ZERO)
  endtask : uninit_seq

  task automatic finish_test();
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  initial
  begin
    #300000;
    num_errors++;
    finish_test();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    `CHK(pdn, 1'b1)
    init_seq();
    low_power_keep();
    swing_seq();
    uninit_seq();
    finish_test();
  end
endmodule : cps_top_test
